// file: design/gpio_pkg.sv
package gpio_pkg;

  // Port geometry: seven 8-bit ports, A through G.
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int PIN_COUNT = NUM_PORTS * PORT_W;

  // Port indices of ports with special handling.
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_F = 3'h5;
  localparam logic [2:0] PORT_G = 3'h6;

  // Port G pin positions shared with system functions.
  localparam int G_BKGD_BIT = 0;
  localparam int G_OSC_LO_BIT = 1;
  localparam int G_OSC_HI_BIT = 2;

  // Port A pins that may carry keyboard inputs with a selectable pulldown.
  localparam int KBD_LO_BIT = 4;
  localparam int KBD_PINS = 4;

  // APB map: each port owns a 16-byte block, one word per control register.
  localparam int ADDR_W = 8;
  localparam logic [1:0] FIELD_DATA = 2'h0;
  localparam logic [1:0] FIELD_DIR = 2'h1;
  localparam logic [1:0] FIELD_PULL = 2'h2;
  localparam logic [1:0] FIELD_SLEW = 2'h3;
  localparam logic [ADDR_W-1:0] SYS_OPT_ADDR = 8'h70;
  localparam logic [ADDR_W-1:0] HOLD_CTRL_ADDR = 8'h74;

  // Field positions inside the system options and hold control words.
  localparam int SYSTEM_OPTIONS_REGISTER_BKGD_EN_BIT = 0;
  localparam int HOLD_RELEASE_BIT = 0;
  localparam int HOLD_MODE_SEL_BIT = 1;

  // Reset values.
  localparam logic [PORT_W-1:0] PORT_REG_RST = 8'h00;
  localparam logic BKGD_EN_RST = 1'b1;

  // Edges after reset release before the synchronised mode-select level is valid.
  localparam logic [1:0] MODE_SEL_SYNC_EDGES = 2'h2;

  // Low-power mode requested together with the stop entry strobe.
  typedef enum logic [1:0] {
    STOP_RUN,
    STOP_DEEP,
    STOP_HOLD,
    STOP_LIGHT
  } stop_kind_type;

endpackage : gpio_pkg

// file: design/port_pins_if.sv
interface port_pins_if;
  // Software-side control bits of one port.
  logic [7:0] dataLatch;
  logic [7:0] dirBits;
  logic [7:0] pullEnBits;
  logic [7:0] slewEnBits;
  // Peripheral ownership of each pin.
  logic [7:0] periphOwn;
  logic [7:0] periphOe;
  logic [7:0] periphOut;
  logic [7:0] periphSlewCap;
  // Synchronised pin level.
  logic [7:0] pinLevel;
  // Resolved pin controls and read-back.
  logic [7:0] padOut;
  logic [7:0] padOeN;
  logic [7:0] padPull;
  logic [7:0] padSlew;
  logic [7:0] readBack;

  modport slice (
    input dataLatch, dirBits, pullEnBits, slewEnBits,
    input periphOwn, periphOe, periphOut, periphSlewCap, pinLevel,
    output padOut, padOeN, padPull, padSlew, readBack
  );

  modport ctrl (
    output dataLatch, dirBits, pullEnBits, slewEnBits,
    output periphOwn, periphOe, periphOut, periphSlewCap, pinLevel,
    input padOut, padOeN, padPull, padSlew, readBack
  );
endinterface : port_pins_if

// file: design/bit_sync.sv
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  // The first stage feeds only the second one.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      syncOut <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end

endmodule : bit_sync

// file: design/io_port_slice.sv
module io_port_slice (
  // Port control and pin resolution
  port_pins_if.slice port
);

  assign port.padOut = (port.periphOwn & port.periphOut) | (~port.periphOwn & port.dataLatch);

  assign port.padOeN = ~((port.periphOwn & port.periphOe) | (~port.periphOwn & port.dirBits));

  assign port.padPull = port.pullEnBits & ~port.dirBits;

  assign port.padSlew = port.slewEnBits &
    ((~port.periphOwn & port.dirBits) | (port.periphOwn & port.periphOe & port.periphSlewCap));

  assign port.readBack = (port.dirBits & port.dataLatch) | (~port.dirBits & port.pinLevel);

endmodule : io_port_slice

// file: design/parallel_io_port_control.sv
module parallel_io_port_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads, port A bit 0 at index 0, port G bit 7 at index 55
  input wire logic [gpio_pkg::PIN_COUNT-1:0] padIn,
  output logic [gpio_pkg::PIN_COUNT-1:0] padOut,
  output logic [gpio_pkg::PIN_COUNT-1:0] padOeN,
  output logic [gpio_pkg::PIN_COUNT-1:0] padPullUp,
  output logic [gpio_pkg::PIN_COUNT-1:0] padSlew,
  output logic [gpio_pkg::KBD_PINS-1:0] kbdPullDown,
  // On-chip peripherals
  input wire logic [gpio_pkg::PIN_COUNT-1:0] periphOwn,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] periphOe,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] periphOut,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] periphSlewCap,
  input wire logic [gpio_pkg::KBD_PINS-1:0] kbdRisingEdge,
  // Background debug and clock generator
  input wire logic bkgdDriveEn,
  input wire logic bkgdDriveOut,
  input wire logic oscPinsEn,
  output logic bkgdIn,
  output logic modeSelect,
  // Power management
  input wire logic stopEnter,
  input wire gpio_pkg::stop_kind_type stopKind,
  output logic pinHoldActive
);

  // Shorthands for the flat pad vectors, where a pin sits at port times width plus bit.
  localparam int NP = gpio_pkg::NUM_PORTS;
  localparam int PW = gpio_pkg::PORT_W;
  localparam int GB = gpio_pkg::PORT_G * gpio_pkg::PORT_W;
  localparam int KB = gpio_pkg::PORT_A * gpio_pkg::PORT_W + gpio_pkg::KBD_LO_BIT;

  // Software-visible controls, one entry per port.
  logic [PW-1:0] dataLatch_r [NP];
  logic [PW-1:0] dirBits_r [NP];
  logic [PW-1:0] pullEnBits_r [NP];
  logic [PW-1:0] slewEnBits_r [NP];

  // System options and the mode-select capture.
  logic bkgdEn_r;
  logic modeSelect_r;
  logic modeCapDone_r;
  logic [1:0] relCnt_r;
  logic [1:0] relCnt_nxt;

  // Pad hold state for the intermediate stop.
  logic pinHold_r;
  logic [gpio_pkg::PIN_COUNT-1:0] holdOut_r;
  logic [gpio_pkg::PIN_COUNT-1:0] holdOeN_r;
  logic [gpio_pkg::PIN_COUNT-1:0] holdPull_r;
  logic [gpio_pkg::PIN_COUNT-1:0] holdSlew_r;
  logic [gpio_pkg::KBD_PINS-1:0] holdPullDown_r;

  // Read data stands from its setup phase until the next one.
  logic [31:0] prdata_r;

  // Per-pin resolution, flat over all seven ports.
  logic [gpio_pkg::PIN_COUNT-1:0] pinLevel;
  logic [gpio_pkg::PIN_COUNT-1:0] ownEff;
  logic [gpio_pkg::PIN_COUNT-1:0] oeEff;
  logic [gpio_pkg::PIN_COUNT-1:0] outEff;
  logic [gpio_pkg::PIN_COUNT-1:0] sliceOut;
  logic [gpio_pkg::PIN_COUNT-1:0] sliceOeN;
  logic [gpio_pkg::PIN_COUNT-1:0] slicePull;
  logic [gpio_pkg::PIN_COUNT-1:0] sliceSlew;
  logic [gpio_pkg::PIN_COUNT-1:0] sliceRead;
  logic [gpio_pkg::PIN_COUNT-1:0] liveOut;
  logic [gpio_pkg::PIN_COUNT-1:0] liveOeN;
  logic [gpio_pkg::PIN_COUNT-1:0] livePull;
  logic [gpio_pkg::KBD_PINS-1:0] livePullDown;
  logic [gpio_pkg::KBD_PINS-1:0] kbdDown;

  // Bus decode and stop strobes.
  logic [2:0] portSel;
  logic [1:0] fieldSel;
  logic portHit;
  logic soptHit;
  logic holdHit;
  logic mapped;
  logic setupPhase;
  logic writeStrobe;
  logic deepStop;
  logic holdStop;
  logic holdRelease;

  // APB decode; the address is stable over setup and access.
  assign portSel = paddr[6:4];
  assign fieldSel = paddr[3:2];
  assign portHit = !paddr[7] && (portSel < 3'(NP)) && (paddr[1:0] == 2'h0);
  assign soptHit = (paddr == gpio_pkg::SYS_OPT_ADDR);
  assign holdHit = (paddr == gpio_pkg::HOLD_CTRL_ADDR);
  assign mapped = portHit || soptHit || holdHit;
  assign setupPhase = psel && !penable;
  assign writeStrobe = psel && penable && pwrite && mapped;
  // Zero wait states: every access, mapped or not, ends in one access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // light stop ignored
  // A light stop keeps the core powered, so registers and pads simply carry on.
  assign deepStop = stopEnter && (stopKind == gpio_pkg::STOP_DEEP);
  assign holdStop = stopEnter && (stopKind == gpio_pkg::STOP_HOLD);
  assign holdRelease = writeStrobe && holdHit && pwdata[gpio_pkg::HOLD_RELEASE_BIT];

  // Pins come from outside the clock domain.
  bit_sync #(
    .WIDTH(gpio_pkg::PIN_COUNT)
  ) padSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(padIn),
    .syncOut(pinLevel)
  );

  // Ownership per pin before the common slice logic resolves it.
  always_comb begin
    ownEff = periphOwn;
    oeEff = periphOe;
    outEff = periphOut;
    // Port F has no peripheral, so any ownership claim on it is dropped.
    // port F unshared
    ownEff[gpio_pkg::PORT_F*PW +: PW] = '0;
    // G0 is not driven until the mode-select level has been caught.
    // background owns G0
    ownEff[GB + gpio_pkg::G_BKGD_BIT] = bkgdEn_r;
    oeEff[GB + gpio_pkg::G_BKGD_BIT] = bkgdDriveEn && modeCapDone_r;
    outEff[GB + gpio_pkg::G_BKGD_BIT] = bkgdDriveOut;
    ownEff[GB + gpio_pkg::G_OSC_LO_BIT] = oscPinsEn;
    ownEff[GB + gpio_pkg::G_OSC_HI_BIT] = oscPinsEn;
    oeEff[GB + gpio_pkg::G_OSC_LO_BIT] = 1'b0;
    oeEff[GB + gpio_pkg::G_OSC_HI_BIT] = 1'b0;
  end

  // Each slice sees one port; the flat vectors stay at this level.
  // one slice per port
  for (genvar p = 0; p < NP; p++) begin : gPort
    port_pins_if portBus ();
    assign portBus.dataLatch = dataLatch_r[p];
    assign portBus.dirBits = dirBits_r[p];
    assign portBus.pullEnBits = pullEnBits_r[p];
    assign portBus.slewEnBits = slewEnBits_r[p];
    assign portBus.periphOwn = ownEff[p*PW +: PW];
    assign portBus.periphOe = oeEff[p*PW +: PW];
    assign portBus.periphOut = outEff[p*PW +: PW];
    assign portBus.periphSlewCap = periphSlewCap[p*PW +: PW];
    assign portBus.pinLevel = pinLevel[p*PW +: PW];
    assign sliceOut[p*PW +: PW] = portBus.padOut;
    assign sliceOeN[p*PW +: PW] = portBus.padOeN;
    assign slicePull[p*PW +: PW] = portBus.padPull;
    assign sliceSlew[p*PW +: PW] = portBus.padSlew;
    assign sliceRead[p*PW +: PW] = portBus.readBack;
    io_port_slice slice (
      .port(portBus)
    );
  end

  // Pull resistor resolution for the shared pins.
  always_comb begin
    livePull = slicePull;
    // G0 pull follows background
    // Without the background function G0's own pullup enable is ignored, so it has no pullup even as an input.
    livePull[GB + gpio_pkg::G_BKGD_BIT] = bkgdEn_r;
    // A crystal must not see a pullup on its pins.
    if (oscPinsEn) begin
      livePull[GB + gpio_pkg::G_OSC_LO_BIT] = 1'b0;
      livePull[GB + gpio_pkg::G_OSC_HI_BIT] = 1'b0;
    end
    // The pulldown replaces the pullup only while the keyboard owns the pin.
    // rising edge pulldown
    kbdDown = kbdRisingEdge & periphOwn[KB +: gpio_pkg::KBD_PINS];
    livePullDown = slicePull[KB +: gpio_pkg::KBD_PINS] & kbdDown;
    livePull[KB +: gpio_pkg::KBD_PINS] = slicePull[KB +: gpio_pkg::KBD_PINS] & ~kbdDown;
  end

  // Hold capture and pad mux read the same nets, so a capture matches the pads.
  assign liveOut = sliceOut;
  assign liveOeN = sliceOeN;

  // While held, the pads ignore the registers, so software may rebuild them.
  // hold mux at pads
  assign padOut = pinHold_r ? holdOut_r : liveOut;
  assign padOeN = pinHold_r ? holdOeN_r : liveOeN;
  assign padPullUp = pinHold_r ? holdPull_r : livePull;
  assign padSlew = pinHold_r ? holdSlew_r : sliceSlew;
  assign kbdPullDown = pinHold_r ? holdPullDown_r : livePullDown;
  assign pinHoldActive = pinHold_r;
  assign modeSelect = modeSelect_r;
  assign bkgdIn = pinLevel[GB + gpio_pkg::G_BKGD_BIT];

  // Port control registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NP; p++) begin
        dataLatch_r[p] <= gpio_pkg::PORT_REG_RST;
        dirBits_r[p] <= gpio_pkg::PORT_REG_RST;
        pullEnBits_r[p] <= gpio_pkg::PORT_REG_RST;
        slewEnBits_r[p] <= gpio_pkg::PORT_REG_RST;
      end
    end else if (deepStop || holdStop) begin
      // Both kinds of power-down stop lose the register contents.
      // stop clears registers
      for (int p = 0; p < NP; p++) begin
        dataLatch_r[p] <= gpio_pkg::PORT_REG_RST;
        dirBits_r[p] <= gpio_pkg::PORT_REG_RST;
        pullEnBits_r[p] <= gpio_pkg::PORT_REG_RST;
        slewEnBits_r[p] <= gpio_pkg::PORT_REG_RST;
      end
    end else if (writeStrobe && portHit) begin
      case (fieldSel)
        gpio_pkg::FIELD_DATA: dataLatch_r[portSel] <= pwdata[PW-1:0];
        gpio_pkg::FIELD_DIR: dirBits_r[portSel] <= pwdata[PW-1:0];
        gpio_pkg::FIELD_PULL: pullEnBits_r[portSel] <= pwdata[PW-1:0];
        gpio_pkg::FIELD_SLEW: slewEnBits_r[portSel] <= pwdata[PW-1:0];
        default: dataLatch_r[portSel] <= dataLatch_r[portSel];
      endcase
    end
  end

  // A power-down stop brings the background function back, as a reset does.
  // background enable register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bkgdEn_r <= gpio_pkg::BKGD_EN_RST;
    end else if (deepStop || holdStop) begin
      bkgdEn_r <= gpio_pkg::BKGD_EN_RST;
    end else if (writeStrobe && soptHit) begin
      bkgdEn_r <= pwdata[gpio_pkg::SYSTEM_OPTIONS_REGISTER_BKGD_EN_BIT];
    end
  end

  // The synchroniser needs two edges after release before the pin level is valid.
  // catch mode select after release
  assign relCnt_nxt = modeCapDone_r ? relCnt_r : relCnt_r + 2'h1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      relCnt_r <= 2'h0;
      modeCapDone_r <= 1'b0;
      modeSelect_r <= 1'b0;
    end else begin
      relCnt_r <= relCnt_nxt;
      if (!modeCapDone_r && relCnt_r == gpio_pkg::MODE_SEL_SYNC_EDGES) begin
        modeSelect_r <= pinLevel[GB + gpio_pkg::G_BKGD_BIT];
        modeCapDone_r <= 1'b1;
      end
    end
  end

  // Pad hold across intermediate stop; entry outranks a release in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinHold_r <= 1'b0;
      holdOut_r <= '0;
      holdOeN_r <= '1;
      holdPull_r <= '0;
      holdSlew_r <= '0;
      holdPullDown_r <= '0;
    end else if (holdStop && !pinHold_r) begin
      // A second hold entry while held must not recapture the pads.
      // latch pins on entry
      pinHold_r <= 1'b1;
      holdOut_r <= liveOut;
      holdOeN_r <= liveOeN;
      holdPull_r <= livePull;
      holdSlew_r <= sliceSlew;
      holdPullDown_r <= livePullDown;
    end else if (deepStop) begin
      pinHold_r <= 1'b0;
    end else if (holdRelease && !holdStop) begin
      pinHold_r <= 1'b0;
    end
  end

  // Read data is registered in the setup phase, so the access phase needs no wait state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata_r <= 32'h0000_0000;
      if (portHit) begin
        case (fieldSel)
          // Only the low byte carries port data; the rest reads as zero.
          // read source
          gpio_pkg::FIELD_DATA: prdata_r[PW-1:0] <= sliceRead[portSel*PW +: PW];
          gpio_pkg::FIELD_DIR: prdata_r[PW-1:0] <= dirBits_r[portSel];
          gpio_pkg::FIELD_PULL: prdata_r[PW-1:0] <= pullEnBits_r[portSel];
          gpio_pkg::FIELD_SLEW: prdata_r[PW-1:0] <= slewEnBits_r[portSel];
          default: prdata_r <= 32'h0000_0000;
        endcase
        // For G0 the pin wins over the latch whatever the direction bit says.
        // G0 reads the pin
        if (fieldSel == gpio_pkg::FIELD_DATA && portSel == gpio_pkg::PORT_G) begin
          prdata_r[gpio_pkg::G_BKGD_BIT] <= pinLevel[GB + gpio_pkg::G_BKGD_BIT];
        end
      end else if (soptHit) begin
        prdata_r[gpio_pkg::SYSTEM_OPTIONS_REGISTER_BKGD_EN_BIT] <= bkgdEn_r;
      end else if (holdHit) begin
        prdata_r[gpio_pkg::HOLD_RELEASE_BIT] <= pinHold_r;
        prdata_r[gpio_pkg::HOLD_MODE_SEL_BIT] <= modeSelect_r;
      end
    end
  end

endmodule : parallel_io_port_control

// file: tb/gpio_checker.sv
module gpio_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pads and peripherals
  input wire logic [55:0] padOut,
  input wire logic [55:0] padOeN,
  input wire logic [55:0] padPullUp,
  input wire logic [55:0] periphOwn,
  input wire logic [55:0] periphOe,
  input wire logic [55:0] periphOut,
  // System
  input wire logic oscPinsEn,
  input wire logic stopEnter,
  input wire gpio_pkg::stop_kind_type stopKind,
  input wire logic pinHoldActive
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ports F and G are left out: port F never follows a peripheral and port G overrides ownership of G0 to G2.
  localparam logic [55:0] LOW_PORTS = 56'h00_00FF_FFFF_FFFF;
  localparam logic [55:0] G0_ONLY = 56'h01_0000_0000_0000;
  logic mapped;
  assign mapped = (paddr < 8'h70) ? (paddr[1:0] == 2'h0) : (paddr == 8'h70 || paddr == 8'h74);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_access;
    psel && penable;
  endsequence
  sequence s_release;
    pinHoldActive && psel && penable && pwrite && paddr == 8'h74 && pwdata[0] && !stopEnter;
  endsequence

  property p_ready;
    s_access |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_refuse;
    s_access |-> pslverr == !mapped;
  endproperty
  a_refuse: assert property (p_refuse) else $error("pslverr wrong");
  property p_resetPins;
    $fell(rst) |-> padOeN == '1 && padOut == '0 && padPullUp == G0_ONLY;
  endproperty
  a_resetPins: assert property (p_resetPins) else $error("pins not in reset state");
  property p_periph;
    !pinHoldActive |-> ((padOeN ^ ~periphOe) & periphOwn & LOW_PORTS) == '0
      && ((padOut ^ periphOut) & periphOwn & periphOe & LOW_PORTS) == '0;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral drive not passed");
  property p_osc;
    oscPinsEn && !pinHoldActive |-> padOeN[50:49] == 2'h3 && padPullUp[50:49] == 2'h0;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator pins not released");
  property p_pullOff;
    !pinHoldActive |-> (~padOeN & padPullUp & ~(periphOwn & LOW_PORTS) & ~G0_ONLY) == '0;
  endproperty
  a_pullOff: assert property (p_pullOff) else $error("pullup on driven pin");
  property p_frozen;
    pinHoldActive && $past(pinHoldActive) |-> $stable(padOeN) && $stable(padOut);
  endproperty
  a_frozen: assert property (p_frozen) else $error("held pins moved");
  property p_holdEnter;
    stopEnter && stopKind == gpio_pkg::STOP_HOLD |=> pinHoldActive;
  endproperty
  a_holdEnter: assert property (p_holdEnter) else $error("hold not entered");
  property p_holdRelease;
    s_release |=> !pinHoldActive;
  endproperty
  a_holdRelease: assert property (p_holdRelease) else $error("hold not released");
  property p_deep;
    stopEnter && stopKind == gpio_pkg::STOP_DEEP && periphOwn == '0
      |=> !pinHoldActive && padPullUp == G0_ONLY && (padOeN | G0_ONLY) == '1;
  endproperty
  a_deep: assert property (p_deep) else $error("deep stop left pins active");
endmodule : gpio_checker

bind parallel_io_port_control gpio_checker i_gpio_checker (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .padOut, .padOeN, .padPullUp, .periphOwn, .periphOe, .periphOut, .oscPinsEn,
  .stopEnter, .stopKind, .pinHoldActive);

// file: tb/board_model.sv
module board_model (
  // Clock
  input wire logic sys_clk,
  // Device pads
  input wire logic [55:0] padOut,
  input wire logic [55:0] padOeN,
  input wire logic [55:0] padPullUp,
  input wire logic [3:0] kbdPullDown,
  // Board drivers
  input wire logic [55:0] boardDrive,
  input wire logic [55:0] boardVal,
  output logic [55:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pin flips every cycle so that a read of it can never match by luck.
  logic [55:0] lastLvl = '0;
  always_ff @(posedge sys_clk) begin
    lastLvl <= padIn;
  end
  always_comb begin
    for (int i = 0; i < 56; i++) begin
      if (!padOeN[i]) padIn[i] = padOut[i];
      else if (boardDrive[i]) padIn[i] = boardVal[i];
      else if (padPullUp[i]) padIn[i] = 1'b1;
      else if (i >= 4 && i < 8 && kbdPullDown[i-4]) padIn[i] = 1'b0;
      else padIn[i] = ~lastLvl[i];
    end
  end
endmodule : board_model

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic bkgdDriveEn, bkgdDriveOut, oscPinsEn, bkgdIn, modeSelect, stopEnter, pinHoldActive;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [55:0] padIn, padOut, padOeN, padPullUp, padSlew, periphOwn, periphOe, periphOut, periphSlewCap;
  logic [55:0] boardDrive, boardVal;
  logic [3:0] kbdPullDown, kbdRisingEdge;
  gpio_pkg::stop_kind_type stopKind;
  int failCount, nTests;

  parallel_io_port_control i_parallel_io_port_control (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .padIn, .padOut, .padOeN, .padPullUp, .padSlew, .kbdPullDown, .periphOwn,
    .periphOe, .periphOut, .periphSlewCap, .kbdRisingEdge, .bkgdDriveEn, .bkgdDriveOut, .oscPinsEn, .bkgdIn,
    .modeSelect, .stopEnter, .stopKind, .pinHoldActive);
  board_model i_board_model (.sys_clk, .padOut, .padOeN, .padPullUp, .kbdPullDown, .boardDrive, .boardVal, .padIn);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic endSim();
    if (failCount == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : endSim

  task automatic cmpBus(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch t=%0t bus %h exp %h", $time, got, exp);
    end
  endtask : cmpBus

  task automatic cmpPins(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch t=%0t pins %h exp %h", $time, got, exp);
    end
  endtask : cmpPins

  // Starts the setup phase just after the next clock edge; the request is held until pready is seen high.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failCount++;
      $display("mismatch t=%0t bus hang", $time);
      endSim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, 32'h0000_0000, r, e);
    cmpBus(r, exp);
  endtask : rdChk

  task automatic stopPulse(input gpio_pkg::stop_kind_type k);
    @(posedge sys_clk);
    stopEnter <= 1'b1;
    stopKind <= k;
    @(posedge sys_clk);
    stopEnter <= 1'b0;
    stopKind <= gpio_pkg::STOP_RUN;
    @(negedge sys_clk);
  endtask : stopPulse

  task automatic tReset();
    logic [31:0] r;
    logic e;
    for (int p = 0; p < 7; p++) begin
      for (int f = 1; f < 4; f++) begin
        rdChk(8'(p * 16 + f * 4), 32'h0000_0000);
      end
      cmpPins(padOeN[p*8 +: 8], 8'hFF);
    end
    cmpPins(padPullUp[55:48], 8'h01);
    rdChk(8'h70, 32'h0000_0001);
    rdChk(8'h74, 32'h0000_0002);
    cmpPins({6'h0, modeSelect, bkgdIn}, 8'h03);
    xfer(8'h78, 1'b0, 32'h0000_0000, r, e);
    cmpBus({r[31:1], e}, 32'h0000_0001);
  endtask : tReset

  task automatic tPorts();
    logic [7:0] v;
    for (int p = 0; p < 6; p++) begin
      v = 8'(8'h3C + p);
      wr(8'(p * 16), {24'h0, ~v});
      cmpPins(padOeN[p*8 +: 8], 8'hFF);
      boardDrive[p*8 +: 8] <= 8'hFF;
      boardVal[p*8 +: 8] <= v;
      repeat (3) @(posedge sys_clk);
      rdChk(8'(p * 16), {24'h0, v});
      boardDrive[p*8 +: 8] <= 8'h00;
      wr(8'(p * 16 + 4), 32'h0000_00FF);
      @(negedge sys_clk);
      cmpPins(padOut[p*8 +: 8], ~v);
      rdChk(8'(p * 16), {24'h0, ~v});
      wr(8'(p * 16), {24'h0, v});
      @(negedge sys_clk);
      cmpPins(padOut[p*8 +: 8], v);
    end
  endtask : tPorts

  task automatic tPeriph();
    wr(8'h10, 32'h0000_005A);
    wr(8'h14, 32'h0000_000F);
    wr(8'h18, 32'h0000_00FF);
    wr(8'h1C, 32'h0000_00FF);
    @(negedge sys_clk);
    cmpPins(padPullUp[15:8], 8'hF0);
    cmpPins(padSlew[15:8], 8'h0F);
    @(posedge sys_clk);
    periphOwn[15:8] <= 8'hFF;
    periphOe[15:8] <= 8'hC0;
    periphOut[15:8] <= 8'h40;
    periphSlewCap[15:8] <= 8'h80;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmpPins(padOeN[15:8], 8'h3F);
    cmpPins(padSlew[15:8], 8'h80);
    cmpPins(padPullUp[15:8], 8'hF0);
    rdChk(8'h10, 32'h0000_007A);
    @(posedge sys_clk);
    {periphOwn, periphOe, periphOut, periphSlewCap} <= '0;
  endtask : tPeriph

  task automatic tKbd();
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_00FF);
    @(posedge sys_clk);
    periphOwn[7:4] <= 4'hF;
    kbdRisingEdge <= 4'h5;
    @(negedge sys_clk);
    cmpPins(padPullUp[7:0], 8'hAF);
    cmpPins({4'h0, kbdPullDown}, 8'h05);
    @(posedge sys_clk);
    periphOwn[7:4] <= 4'h0;
    kbdRisingEdge <= 4'h0;
  endtask : tKbd

  task automatic tPortF();
    @(posedge sys_clk);
    periphOwn[47:40] <= 8'hFF;
    periphOe[47:40] <= 8'hFF;
    periphOut[47:40] <= 8'hFF;
    wr(8'h50, 32'h0000_0000);
    wr(8'h54, 32'h0000_000F);
    @(negedge sys_clk);
    cmpPins(padOeN[47:40], 8'hF0);
    cmpPins(padOut[47:40] & 8'h0F, 8'h00);
    @(posedge sys_clk);
    {periphOwn, periphOe, periphOut} <= '0;
  endtask : tPortF

  task automatic tPortG();
    wr(8'h68, 32'h0000_0000);
    wr(8'h64, 32'h0000_00FF);
    wr(8'h60, 32'h0000_00FF);
    @(negedge sys_clk);
    cmpPins(padPullUp[55:48], 8'h01);
    cmpPins(padOeN[55:48], 8'h01);
    @(posedge sys_clk);
    bkgdDriveEn <= 1'b1;
    oscPinsEn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmpPins(padOeN[55:48], 8'h06);
    rdChk(8'h60, 32'h0000_00FE);
    @(posedge sys_clk);
    bkgdDriveEn <= 1'b0;
    oscPinsEn <= 1'b0;
    wr(8'h70, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmpPins(padOeN[55:48], 8'h00);
    cmpPins(padPullUp[55:48], 8'h00);
    rdChk(8'h60, 32'h0000_00FF);
    wr(8'h68, 32'h0000_0001);
    wr(8'h64, 32'h0000_00FE);
    @(negedge sys_clk);
    cmpPins(padPullUp[55:48], 8'h00);
  endtask : tPortG

  task automatic tStop();
    stopPulse(gpio_pkg::STOP_LIGHT);
    cmpPins(padOut[23:16], 8'h3E);
    rdChk(8'h24, 32'h0000_00FF);
    stopPulse(gpio_pkg::STOP_HOLD);
    cmpPins(padOeN[23:16], 8'h00);
    rdChk(8'h24, 32'h0000_0000);
    rdChk(8'h74, 32'h0000_0003);
    wr(8'h20, 32'h0000_003E);
    wr(8'h24, 32'h0000_00FF);
    wr(8'h74, 32'h0000_0001);
    @(negedge sys_clk);
    cmpPins({7'h0, pinHoldActive}, 8'h00);
    wr(8'h20, 32'h0000_0055);
    @(negedge sys_clk);
    cmpPins(padOut[23:16], 8'h55);
    stopPulse(gpio_pkg::STOP_DEEP);
    cmpPins(padOeN[23:16], 8'hFF);
    rdChk(8'h70, 32'h0000_0001);
  endtask : tStop

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, bkgdDriveEn, bkgdDriveOut, oscPinsEn, stopEnter} = '0;
    {paddr, pwdata, periphOwn, periphOe, periphOut, periphSlewCap, boardDrive, boardVal, kbdRisingEdge} = '0;
    stopKind = gpio_pkg::STOP_RUN;
    failCount = 0;
    nTests = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    tReset();
    tPorts();
    tPeriph();
    tKbd();
    tPortF();
    tPortG();
    tStop();
    endSim();
  end

  // A hang anywhere still ends in the verdict rather than running forever.
  initial begin
    repeat (50000) @(posedge sys_clk);
    failCount++;
    $display("mismatch t=%0t run limit", $time);
    endSim();
  end
endmodule : tb
